/* scratchpad_device.sv */
// device end: write, read and copy scratchpad with crc and password
// assumes link strobes are synchronous to clk_i and one cycle wide
//
// Notes on behaviour
// - write cmd then address low, high
// - status low five bits: ending offset; bit6 zero
// - partial byte sets flag, byte dropped
// - copy sets accepted flag; write clears it
// - data stored from target offset up to 1Fh
// - copy refused unless ending offset 1Fh
// - master writes until ending offset 1Fh
// - read returns address, status, then data
// - read ends with inverted crc, then ones
// - write crc covers cmd, address, data
// - full write answers inverted crc on reads
// - writes always accepted, even in mission
// - copy sends auth bytes then password
// - bad password: go silent until reset
// - good password and auth: flag, copy
// - after copy, send alternating ones/zeros
// - bus reset ignored while copying
// - copy takes about 2 us per byte
// - copy begin to ending offset at target
// - data and calibration pages always copyable
// - register pages refused during mission
// - standard speed until overdrive selected
// - password sent bit zero first
`timescale 1ns/10ps
`include "link_params.svh"
module scratchpad_device (
	input wire logic clk_i,                   // system clock
	input wire logic rst_i,                   // sync reset, high
	link_if.device link,                      // link from the master
	input wire logic [63:0] full_password_i,  // stored full-access password
	input wire logic password_enable_i,       // password checking on
	input wire logic mission_running_flag_i,  // mission in progress
	input wire logic [9:0] mem_addr_i,        // memory peek address
	output logic [7:0] mem_data_o,            // memory peek data
	output logic [7:0] status_o,              // ending offset and status
	output logic copy_busy_o                  // copy in progress
);
	import link_pkg::*;

	typedef struct packed {
		dev_state_type state;
		tx_sel_type tx_sel;
		logic [7:0] rx_sh;
		logic [7:0] tx_sh;
		logic [7:0] target_address_low;
		logic [7:0] target_address_high;
		logic [2:0] bit_cnt;
		logic [3:0] idx;
		logic [4:0] ending;
		logic [4:0] offset;
		logic [4:0] cp_src;
		logic partial_byte_flag;
		logic copy_accepted_flag;
		logic full;
		logic pw_ok;
		logic [15:0] crc;
		logic [15:0] cp_addr;
		logic [23:0] auth;
		logic [6:0] wait_cnt;
		logic [31:0][7:0] scratch;
	} dev_reg_type;

	dev_reg_type st, n;
	logic [7:0] mem [0:`MEM_BYTES - 1];
	logic wr_slot;
	logic rd_slot;
	logic byte_done;
	logic [7:0] rx_byte;
	logic [7:0] es;
	logic [7:0] pw_byte;
	logic [15:0] target;
	logic reg_page;
	logic pass_ok;
	logic mem_we;
	logic [15:0] crc_tx;

	// crc16 one bit at a time, reflected polynomial
	function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
		crc_bit = (c[0] ^ b) ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
	endfunction

	// status byte: accepted flag, zero, partial flag, ending offset
	assign es = {st.copy_accepted_flag, 1'b0, st.partial_byte_flag, st.ending};
	assign target = {st.target_address_high, st.target_address_low};
	assign reg_page = target >= `REG_PAGE_LO && target <= `REG_PAGE_HI;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		n = st;
		mem_we = 1'b0;
		wr_slot = link.slot && link.slot_write;
		rd_slot = link.slot && !link.slot_write;
		rx_byte = {link.wbit, st.rx_sh[7:1]};
		byte_done = wr_slot && st.bit_cnt == `BYTE_LAST;
		pw_byte = full_password_i[{st.idx[2:0], 3'h0} +: 8];
		pass_ok = !password_enable_i || (st.pw_ok && rx_byte == pw_byte);
		crc_tx = crc_bit(st.crc, st.tx_sh[0]);
		// shared receiver: lsb first, crc follows every bit received
		if (wr_slot && st.state inside {D_IDLE, D_W_ADDR, D_W_DATA, D_C_AUTH, D_C_PASS}) begin
			n.rx_sh = rx_byte;
			n.bit_cnt = st.bit_cnt + 3'h1;
			n.crc = crc_bit(st.crc, link.wbit);
		end
		case (st.state)
			D_IDLE: begin
				if (byte_done) begin
					n.idx = 4'h0;
					case (rx_byte)
						`CMD_WRITE_SP: begin
							// taken at any time, mission or not
							n.state = D_W_ADDR;
							n.copy_accepted_flag = 1'b0;
							n.partial_byte_flag = 1'b0;
							n.full = 1'b0;
						end
						`CMD_READ_SP: begin
							n.state = D_TX;
							n.tx_sel = TX_HDR;
							n.tx_sh = st.target_address_low;
							n.offset = st.target_address_low[4:0];
						end
						`CMD_COPY_SP: n.state = D_C_AUTH;
						default: begin
							n.state = D_TX;
							n.tx_sel = TX_ONES;
						end
					endcase
				end
			end
			D_W_ADDR: begin
				if (byte_done) begin
					n.idx = st.idx + 4'h1;
					if (st.idx == 4'h0) begin
						n.target_address_low = rx_byte;
						n.offset = rx_byte[4:0];
						n.ending = rx_byte[4:0];
					end else begin
						n.target_address_high = rx_byte;
						n.state = D_W_DATA;
					end
				end
			end
			D_W_DATA: begin
				if (wr_slot) begin
					n.tx_sh = `ONES_BYTE;
				end
				if (byte_done) begin
					if (!st.full) begin
						n.scratch[st.offset] = rx_byte;
						n.ending = st.offset;
						n.full = st.offset == `END_OFS;
						n.offset = st.offset + 5'h1;
					end
					// crc is ready for the next read slot once full
					if (st.full || st.offset == `END_OFS) begin
						n.tx_sh = ~n.crc[7:0];
					end
				end
				if (rd_slot) begin
					// an unfinished byte is dropped and flagged
					n.partial_byte_flag = st.partial_byte_flag || st.bit_cnt != 3'h0;
					n.bit_cnt = 3'h0;
					n.state = D_TX;
					n.tx_sel = (st.full && st.bit_cnt == 3'h0) ? TX_CRC_LO : TX_ONES;
				end
			end
			D_C_AUTH: begin
				if (byte_done) begin
					n.auth = {rx_byte, st.auth[23:8]};
					n.idx = st.idx + 4'h1;
					if (st.idx == `AUTH_LAST) begin
						n.state = D_C_PASS;
						n.idx = 4'h0;
						n.pw_ok = 1'b1;
					end
				end
			end
			D_C_PASS: begin
				if (byte_done) begin
					n.pw_ok = st.pw_ok && rx_byte == pw_byte;
					n.idx = st.idx + 4'h1;
					if (st.idx == `PASS_LAST) begin
						n.state = D_TX;
						n.tx_sel = TX_ONES;
						n.tx_sh = `ONES_BYTE;
						// wrong password leaves the device silent
						if (pass_ok && st.auth == {es, target} && st.ending == `END_OFS
							&& !(reg_page && mission_running_flag_i)) begin
							n.copy_accepted_flag = 1'b1;
							n.state = D_COPY;
							n.cp_src = st.target_address_low[4:0];
							n.cp_addr = target;
							n.wait_cnt = 7'h0;
						end
					end
				end
			end
			D_COPY: begin
				// one byte per byte time, no bus activity meanwhile
				if (st.wait_cnt == 7'(`COPY_BYTE_CYC - 1)) begin
					n.wait_cnt = 7'h0;
					mem_we = st.cp_addr < {6'h0, `MEM_BYTES};
					n.cp_addr = st.cp_addr + 16'h1;
					n.cp_src = st.cp_src + 5'h1;
					if (st.cp_src == st.ending) begin
						n.state = D_TX;
						n.tx_sel = TX_ALT;
						n.tx_sh = `ALT_BYTE;
						n.bit_cnt = 3'h0;
					end
				end else begin
					n.wait_cnt = st.wait_cnt + 7'h1;
				end
			end
			D_TX: n.state = D_TX;
			default: n.state = D_IDLE;
		endcase
		// transmitter: one bit per read slot, next byte loaded after bit 7
		if (rd_slot && n.state == D_TX) begin
			n.tx_sh = {1'b1, st.tx_sh[7:1]};
			if (st.tx_sel inside {TX_HDR, TX_DATA}) begin
				n.crc = crc_tx;
			end
			n.bit_cnt = n.bit_cnt + 3'h1;
			if (n.bit_cnt == 3'h0) begin
				case (n.tx_sel)
					TX_HDR: begin
						n.idx = st.idx + 4'h1;
						if (st.idx == 4'h0) begin
							n.tx_sh = st.target_address_high;
						end else if (st.idx == 4'h1) begin
							n.tx_sh = es;
						end else begin
							n.tx_sh = st.scratch[st.offset];
							n.tx_sel = TX_DATA;
						end
					end
					TX_DATA: begin
						if (st.offset == `END_OFS) begin
							n.tx_sh = ~crc_tx[7:0];
							n.tx_sel = TX_CRC_LO;
						end else begin
							n.offset = st.offset + 5'h1;
							n.tx_sh = st.scratch[n.offset];
						end
					end
					TX_CRC_LO: begin
						n.tx_sh = ~st.crc[15:8];
						n.tx_sel = TX_CRC_HI;
					end
					TX_ALT: n.tx_sh = `ALT_BYTE;
					default: begin
						n.tx_sh = `ONES_BYTE;
						n.tx_sel = TX_ONES;
					end
				endcase
			end
		end
		// bus reset aborts everything but a running copy
		if (link.bus_reset && st.state != D_COPY) begin
			if (st.state == D_W_DATA && st.bit_cnt != 3'h0) begin
				n.partial_byte_flag = 1'b1;
			end
			n.state = D_IDLE;
			n.bit_cnt = 3'h0;
			n.crc = 16'h0000;
			n.tx_sel = TX_ONES;
			n.tx_sh = `ONES_BYTE;
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '{state: D_IDLE, tx_sel: TX_ONES, tx_sh: `ONES_BYTE, default: '0};
		end else begin
			st <= n;
		end
	end

	// ****************************************
	// copy target memory
	// ****************************************
	// kept apart from the state struct so it maps onto a ram
	always_ff @(posedge clk_i) begin
		if (mem_we) begin
			mem[st.cp_addr[9:0]] <= st.scratch[st.cp_src];
		end
		mem_data_o <= (mem_addr_i < `MEM_BYTES) ? mem[mem_addr_i] : 8'h00;
	end

	assign link.rbit = st.tx_sh[0];
	assign status_o = es;
	assign copy_busy_o = st.state == D_COPY;
endmodule

/* link_params.svh */
// constants shared by both ends of the scratchpad link
// assumes a 50 MHz system clock on both ends
`ifndef LINK_PARAMS_SVH
`define LINK_PARAMS_SVH

// ****************************************
// command codes
// ****************************************
`define CMD_WRITE_SP 8'h0F
`define CMD_READ_SP 8'hAA
`define CMD_COPY_SP 8'h99

// ****************************************
// scratchpad and status layout
// ****************************************
`define END_OFS 5'h1F
`define BYTE_LAST 3'h7
`define AUTH_LAST 4'h2
`define PASS_LAST 4'h7
`define CRC_POLY 16'hA001
`define ONES_BYTE 8'hFF
`define ALT_BYTE 8'h55
`define MEM_BYTES 10'h280
`define REG_PAGE_LO 16'h0200
`define REG_PAGE_HI 16'h023F

// ****************************************
// timing, in ns and in cycles
// ****************************************
`define CLK_NS 32'h14
`define COPY_BYTE_NS 32'h7D0
`define COPY_BYTE_CYC (`COPY_BYTE_NS / `CLK_NS)
`define RST_STD_NS 32'h75300
`define RST_OD_NS 32'hBB80
`define SLOT_STD_NS 32'hEA60
`define SLOT_OD_NS 32'h1F40

// ****************************************
// wishbone register map of the master
// ****************************************
`define ADR_CTRL 8'h00
`define ADR_DATA 8'h04
`define ADR_CONFIG 8'h08
`define CTRL_RESET 0
`define CTRL_WRITE 1
`define CTRL_READ 2

`endif

/* link_pkg.sv */
// types shared by both ends of the scratchpad link
// assumes link_params.svh for all numeric constants
package link_pkg;
	typedef enum logic [2:0] {D_IDLE, D_W_ADDR, D_W_DATA, D_C_AUTH, D_C_PASS, D_COPY, D_TX}
		dev_state_type;
	typedef enum logic [2:0] {TX_HDR, TX_DATA, TX_CRC_LO, TX_CRC_HI, TX_ONES, TX_ALT} tx_sel_type;
	typedef enum logic [1:0] {M_IDLE, M_RST, M_SLOT} mst_state_type;
endpackage

/* link_if.sv */
// bit-slot level link between bus master and scratchpad device
// assumes both ends share clk; each slot is a one-cycle strobe
`timescale 1ns/10ps
interface link_if;
	logic bus_reset;        // reset pulse level from master
	logic slot;             // one-cycle time slot strobe
	logic slot_write;       // 1 write slot, 0 read slot
	logic wbit;             // bit written in a write slot
	logic rbit;             // bit the device answers in a read slot
	logic overdrive_select; // master speed selection
	modport device (input bus_reset, slot, slot_write, wbit, overdrive_select, output rbit);
	modport master (output bus_reset, slot, slot_write, wbit, overdrive_select, input rbit);
endinterface

/* scratchpad_master.sv */
// bus master end: byte engine for reset pulses and 8-slot bytes
// assumes software drives it over classic wishbone, one byte at a time
`timescale 1ns/10ps
`include "link_params.svh"
module scratchpad_master #(
	parameter int unsigned RST_STD_CYC = `RST_STD_NS / `CLK_NS,
	parameter int unsigned RST_OD_CYC = `RST_OD_NS / `CLK_NS,
	parameter int unsigned SLOT_STD_CYC = `SLOT_STD_NS / `CLK_NS,
	parameter int unsigned SLOT_OD_CYC = `SLOT_OD_NS / `CLK_NS
) (
	input wire logic clk_i,          // system clock
	input wire logic rst_i,          // sync reset, high
	input wire logic [7:0] adr_i,    // wishbone byte address
	input wire logic [31:0] dat_i,   // wishbone write data
	output logic [31:0] dat_o,       // wishbone read data
	input wire logic we_i,           // write enable
	input wire logic [3:0] sel_i,    // byte selects
	input wire logic cyc_i,          // bus cycle
	input wire logic stb_i,          // strobe
	output logic ack_o,              // acknowledge
	link_if.master link              // link to the device
);
	import link_pkg::*;

	typedef struct packed {
		mst_state_type state;
		logic ack;
		logic [31:0] dat;
		logic [7:0] tx;
		logic [7:0] rx;
		logic [2:0] bit_cnt;
		logic [14:0] timer;
		logic overdrive_select;
		logic bus_reset;
		logic slot;
		logic slot_write;
		logic wbit;
	} mst_reg_type;

	mst_reg_type st, n;
	logic req;
	logic idle;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		n = st;
		req = cyc_i && stb_i && !st.ack;
		idle = st.state == M_IDLE;
		n.ack = req;
		// reads answer one cycle after the request; unmapped reads give zero
		case (adr_i)
			`ADR_CTRL: n.dat = {31'h0, !idle};
			`ADR_DATA: n.dat = {24'h0, st.rx};
			`ADR_CONFIG: n.dat = {31'h0, st.overdrive_select};
			default: n.dat = 32'h0;
		endcase
		if (req && we_i && sel_i[0] && idle) begin
			case (adr_i)
				`ADR_DATA: n.tx = dat_i[7:0];
				`ADR_CONFIG: n.overdrive_select = dat_i[0];
				`ADR_CTRL: begin
					if (dat_i[`CTRL_RESET]) begin
						n.state = M_RST;
						n.bus_reset = 1'b1;
						n.timer = st.overdrive_select ? 15'(RST_OD_CYC - 1) : 15'(RST_STD_CYC - 1);
					end else if (dat_i[`CTRL_WRITE] || dat_i[`CTRL_READ]) begin
						// bytes leave lsb first, so passwords go bit 0 to 63
						n.state = M_SLOT;
						n.bit_cnt = 3'h0;
						n.slot = 1'b1;
						n.slot_write = !dat_i[`CTRL_READ];
						n.tx = dat_i[`CTRL_READ] ? `ONES_BYTE : st.tx;
						n.wbit = dat_i[`CTRL_READ] ? 1'b1 : st.tx[0];
					end
				end
				default: n.tx = st.tx;
			endcase
		end
		// slot sequencing; reads are sampled in the strobe cycle
		case (st.state)
			// idle: keep whatever order was taken above, or it would be undone
			M_IDLE: begin
			end
			M_RST: begin
				if (st.timer == 15'h0) begin
					n.bus_reset = 1'b0;
					n.state = M_IDLE;
				end else begin
					n.timer = st.timer - 15'h1;
				end
			end
			M_SLOT: begin
				if (st.slot) begin
					n.slot = 1'b0;
					if (!st.slot_write) begin
						n.rx = {link.rbit, st.rx[7:1]};
					end
					n.timer = st.overdrive_select ? 15'(SLOT_OD_CYC - 1) : 15'(SLOT_STD_CYC - 1);
				end else if (st.timer != 15'h0) begin
					n.timer = st.timer - 15'h1;
				end else if (st.bit_cnt == `BYTE_LAST) begin
					n.state = M_IDLE;
				end else begin
					n.bit_cnt = st.bit_cnt + 3'h1;
					n.tx = {1'b1, st.tx[7:1]};
					n.wbit = st.tx[1];
					n.slot = 1'b1;
				end
			end
			default: n.state = M_IDLE;
		endcase
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '{state: M_IDLE, tx: `ONES_BYTE, wbit: 1'b1, default: '0};
		end else begin
			st <= n;
		end
	end

	assign dat_o = st.dat;
	assign ack_o = st.ack;
	assign link.bus_reset = st.bus_reset;
	assign link.slot = st.slot;
	assign link.slot_write = st.slot_write;
	assign link.wbit = st.wbit;
	assign link.overdrive_select = st.overdrive_select;
endmodule

/* scratchpad_chk.sv */
// checker: link strobes and device status relations of the scratchpad link
// assumes one clock for both ends and a synchronous, active-high reset
`timescale 1ns/10ps
module scratchpad_chk (
	input wire logic clk_i,            // system clock
	input wire logic rst_i,            // sync reset, high
	input wire logic bus_reset,        // reset pulse level
	input wire logic slot,             // time slot strobe
	input wire logic slot_write,       // write slot select
	input wire logic wbit,             // written bit
	input wire logic rbit,             // answered bit
	input wire logic overdrive_select, // speed select
	input wire logic [7:0] status_o,   // device ending offset and status
	input wire logic copy_busy_o       // device copy in progress
);
	localparam logic [12:0] COPY_MAX = 13'hCE4;
	logic [12:0] copy_cnt;

	// ****************************************
	// copy length counter
	// ****************************************
	// counted, since a full copy outlasts any delay range
	always_ff @(posedge clk_i) begin
		if (rst_i || !copy_busy_o) begin
			copy_cnt <= 13'h0;
		end else begin
			copy_cnt <= copy_cnt + 13'h1;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_status_bit_six: assert property (status_o[6] == 1'b0)
		else $error("status bit 6 not zero");
	a_copy_min_time: assert property ($rose(copy_busy_o) |-> copy_busy_o [*8])
		else $error("copy ended too soon");
	a_copy_max_time: assert property (copy_cnt < COPY_MAX)
		else $error("copy runs too long");
	a_copy_byte_time: assert property ($fell(copy_busy_o) |-> copy_cnt >= 13'h60)
		else $error("copy shorter than one byte time");
	a_copy_needs_full: assert property ($rose(copy_busy_o) |-> status_o[4:0] == 5'h1F)
		else $error("copy started without full scratchpad");
	a_accept_clean: assert property ($rose(status_o[7]) |-> status_o[5:0] == 6'h1F)
		else $error("accepted flag set on bad status");
	a_copy_status_hold: assert property (copy_busy_o [*3] |-> $stable(status_o))
		else $error("status changed during copy");
	a_slot_spacing: assert property (slot |=> !slot [*3])
		else $error("slots too close");
	a_reset_no_slot: assert property (bus_reset |-> !slot)
		else $error("slot during reset pulse");
	c_copy: cover property ($fell(copy_busy_o));
	c_accept: cover property ($rose(status_o[7]));
	c_overdrive: cover property (overdrive_select && slot);
endmodule

/* tb.sv */
// testbench: master and device joined, master driven over classic wishbone
// assumes short reset and slot counts set on the master instance
`timescale 1ns/10ps
`include "link_params.svh"
module tb;
	logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, password_enable_i, mission_running_flag_i;
	logic copy_busy_o;
	logic [3:0] sel_i;
	logic [7:0] adr_i, mem_data_o, status_o;
	logic [9:0] mem_addr_i;
	logic [15:0] crc;
	logic [31:0] dat_i, dat_o, q;
	logic [7:0] exp_q[$];
	int n_errors, comparisons;
	localparam logic [63:0] PW = 64'h0123456789ABCDEF;
	link_if link();
	scratchpad_master #(.RST_STD_CYC(4), .RST_OD_CYC(4), .SLOT_STD_CYC(3), .SLOT_OD_CYC(3))
		u_scratchpad_master (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
		.dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.ack_o(ack_o), .link(link));
	scratchpad_device u_scratchpad_device (.clk_i(clk_i), .rst_i(rst_i), .link(link),
		.full_password_i(PW), .password_enable_i(password_enable_i),
		.mission_running_flag_i(mission_running_flag_i), .mem_addr_i(mem_addr_i),
		.mem_data_o(mem_data_o), .status_o(status_o), .copy_busy_o(copy_busy_o));
	scratchpad_chk u_scratchpad_chk (.clk_i(clk_i), .rst_i(rst_i), .bus_reset(link.bus_reset),
		.slot(link.slot), .slot_write(link.slot_write), .wbit(link.wbit), .rbit(link.rbit),
		.overdrive_select(link.overdrive_select), .status_o(status_o),
		.copy_busy_o(copy_busy_o));

	// ****************************************
	// helpers
	// ****************************************
	task automatic summarize();
		if (n_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic hang();
		check(8'h00, 8'h01);
		summarize();
	endtask
	function automatic logic [15:0] crc_of(input logic [7:0] cmd, input logic [7:0] s[$]);
		logic [15:0] c;
		logic [7:0] b;
		c = 16'h0;
		for (int j = 0; j <= s.size(); j++) begin
			b = (j == 0) ? cmd : s[j - 1];
			// lsb first through the reflected polynomial
			for (int i = 0; i < 8; i++) begin
				c = (c[0] ^ b[i]) ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
			end
		end
		return c;
	endfunction
	// one classic cycle, held until ack is sampled; q takes the read data
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && k < 50);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
		if (k >= 50) hang();
	endtask
	// order a link action, then poll busy with a bound
	task automatic ctl(input logic [31:0] v);
		int k;
		k = 0;
		wb(1'b1, `ADR_CTRL, v);
		do begin
			wb(1'b0, `ADR_CTRL, 32'h0);
			k++;
		end while (q[0] !== 1'b0 && k < 200);
		if (k >= 200) hang();
	endtask
	task automatic send(input logic [7:0] b);
		wb(1'b1, `ADR_DATA, {24'h0, b});
		ctl(32'h2);
	endtask
	task automatic recv();
		ctl(32'h4);
		wb(1'b0, `ADR_DATA, 32'h0);
	endtask
	task automatic do_write(input logic [15:0] ta, input int n, input logic [7:0] base);
		ctl(32'h1);
		send(`CMD_WRITE_SP);
		send(ta[7:0]);
		send(ta[15:8]);
		for (int i = 0; i < n; i++) begin
			send(base + 8'(i));
		end
	endtask
	task automatic do_copy(input logic [15:0] ta, input logic [7:0] es, input logic [63:0] pw);
		ctl(32'h1);
		send(`CMD_COPY_SP);
		send(ta[7:0]);
		send(ta[15:8]);
		send(es);
		for (int i = 0; i < 8; i++) begin
			send(pw[8 * i +: 8]);
		end
	endtask
	// wait out the copy, then one byte read and the accepted flag
	task automatic copy_result(input logic [7:0] b, input logic aa);
		int k;
		k = 0;
		while (copy_busy_o === 1'b1 && k < 5000) begin
			@(posedge clk_i);
			k++;
		end
		if (k >= 5000) hang();
		recv();
		check(q[7:0], b);
		check({7'h0, status_o[7]}, {7'h0, aa});
	endtask
	task automatic peek(input logic [9:0] a, input logic [7:0] exp);
		mem_addr_i <= a;
		repeat (2) @(posedge clk_i);
		check(mem_data_o, exp);
	endtask

	// ****************************************
	// clock and sequence
	// ****************************************
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	initial begin
		rst_i = 1'b1;
		{cyc_i, stb_i, we_i, mission_running_flag_i} = 4'h0;
		adr_i = 8'h00;
		dat_i = 32'h0;
		sel_i = 4'hF;
		mem_addr_i = 10'h000;
		password_enable_i = 1'b1;
		n_errors = 0;
		comparisons = 0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check(status_o, 8'h00);
		wb(1'b0, `ADR_CONFIG, 32'h0);
		check(q[7:0], 8'h00);
		// short write at offset 1C, then its crc
		do_write(16'h013C, 4, 8'h40);
		exp_q = '{8'h3C, 8'h01, 8'h40, 8'h41, 8'h42, 8'h43};
		crc = ~crc_of(`CMD_WRITE_SP, exp_q);
		recv();
		check(q[7:0], crc[7:0]);
		recv();
		check(q[7:0], crc[15:8]);
		check(status_o, 8'h1F);
		// read back: address, status, data, crc, then ones
		ctl(32'h1);
		send(`CMD_READ_SP);
		exp_q = '{8'h3C, 8'h01, 8'h1F, 8'h40, 8'h41, 8'h42, 8'h43};
		crc = ~crc_of(`CMD_READ_SP, exp_q);
		exp_q.push_back(crc[7:0]);
		exp_q.push_back(crc[15:8]);
		exp_q.push_back(`ONES_BYTE);
		foreach (exp_q[i]) begin
			recv();
			check(q[7:0], exp_q[i]);
		end
		// good copy with a reset pulse sent while it runs
		do_copy(16'h013C, 8'h1F, PW);
		check({7'h0, copy_busy_o}, 8'h01);
		ctl(32'h1);
		copy_result(`ALT_BYTE, 1'b1);
		for (int i = 0; i < 4; i++) begin
			peek(10'h13C + 10'(i), 8'h40 + 8'(i));
		end
		// mission: register page refused, data page still copied
		mission_running_flag_i <= 1'b1;
		do_write(16'h0200, 32, 8'h80);
		check(status_o, 8'h1F);
		do_copy(16'h0200, 8'h1F, PW);
		copy_result(`ONES_BYTE, 1'b0);
		do_write(16'h0000, 32, 8'h10);
		do_copy(16'h0000, 8'h1F, PW);
		copy_result(`ALT_BYTE, 1'b1);
		peek(10'h01F, 8'h2F);
		// ending offset short of 1F
		mission_running_flag_i <= 1'b0;
		do_write(16'h0000, 2, 8'h20);
		check(status_o, 8'h01);
		do_copy(16'h0000, 8'h01, PW);
		copy_result(`ONES_BYTE, 1'b0);
		// wrong password, checked and then unchecked
		do_write(16'h0000, 32, 8'h30);
		do_copy(16'h0000, 8'h1F, ~PW);
		copy_result(`ONES_BYTE, 1'b0);
		password_enable_i <= 1'b0;
		do_copy(16'h0000, 8'h1F, ~PW);
		copy_result(`ALT_BYTE, 1'b1);
		// overdrive selection and an unmapped address
		wb(1'b1, `ADR_CONFIG, 32'h1);
		wb(1'b0, `ADR_CONFIG, 32'h0);
		check(q[7:0], 8'h01);
		check({7'h0, link.overdrive_select}, 8'h01);
		ctl(32'h1);
		send(`CMD_READ_SP);
		recv();
		check(q[7:0], 8'h00);
		wb(1'b0, 8'h0C, 32'h0);
		check(q[7:0], 8'h00);
		summarize();
	end
endmodule
